// *** hw/usf_status_flags.sv ***
// Status flags, interrupt request and register slave of a serial transceiver.
//
// Behaviour
// - Set holding-empty flag when holding moves to shifter.
// - Holding-empty interrupt when enabled; data write clears.
// - Set complete flag when frame ends, holding empty.
// - Complete interrupt while flag and enable set.
// - Status read then data write, or zero-write, clears complete.
// - Set data-ready flag when received word lands.
// - Data-ready interrupt while flag and enable set.
// - Data write or zero-write clears data-ready flag.
// - Set idle flag when idle line detected.
// - Idle interrupt while flag and enable set.
// - Status read then data read clears idle.
`timescale 1ns/1ps
`default_nettype none
`include "usf_defines.svh"

module usf_status_flags #(
  parameter int DATA_W = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  // Register bus, write address channel.
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // Write data channel.
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // Write response channel.
  output usf_pkg::usf_resp_t S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // Read address channel.
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // Read data channel.
  output logic [31:0] S_AXI_RDATA,
  output usf_pkg::usf_resp_t S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Transmit side: holding register towards the shift register.
  output logic [DATA_W-1:0] TX_HOLD_DATA,
  output logic TX_HOLD_FULL,
  input wire logic TX_SHIFT_LOAD,
  input wire logic TX_FRAME_DONE,
  // Receive side: word from the receive shift register.
  input wire logic [DATA_W-1:0] RX_WORD,
  input wire logic RX_WORD_VALID,
  input wire logic RX_IDLE_DETECT,
  // Interrupt request, high while any enabled cause is present.
  output logic IRQ
);
  import usf_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State.

  logic tx_holding_empty_flag; // Holding register may be written.
  logic tx_complete_flag; // Last frame fully sent.
  logic rx_data_ready_flag; // Received word waiting in the data register.
  logic idle_line_flag; // Idle line seen on the receive input.
  logic tx_holding_empty_irq_en; // Enable for the holding-empty cause.
  logic tx_complete_irq_en; // Enable for the complete cause.
  logic rx_data_ready_irq_en; // Enable for the data-ready cause.
  logic idle_line_irq_en; // Enable for the idle cause.
  logic [DATA_W-1:0] tx_holding_register; // Word waiting for the shifter.
  logic [DATA_W-1:0] rx_data; // Last received word.
  logic tc_armed; // Status read saw the complete flag set.
  logic idle_armed; // Status read saw the idle flag set.
  logic [7:0] evt; // Sticky event bits, cleared by reading them.
  logic [7:0] mask; // Event bits allowed onto the interrupt.

  // Bus side state.
  usf_wr_state_e wr_state; // Write transaction progress.
  logic [7:0] aw_addr; // Held write address.
  logic [31:0] w_data; // Held write data.
  logic [3:0] w_strb; // Held write strobes.
  usf_resp_t bresp; // Response of the finished write.
  logic rvalid; // Read answer pending.
  logic [31:0] rdata; // Read answer data.
  usf_resp_t rresp; // Read answer code.

  //////////////////////////////////////////////////////////////////////////////
  // Write channel handshake.

  logic aw_hs; // Write address taken this cycle.
  logic w_hs; // Write data taken this cycle.
  logic wr_do; // Write executes this cycle.
  logic [7:0] wr_addr; // Address of the executing write.
  logic [31:0] wr_data; // Data of the executing write.
  logic [3:0] wr_strb; // Strobes of the executing write.
  logic wr_lane0; // Low byte lane written; all fields live there.
  logic wr_hit; // Address maps to a register.
  logic wr_stat; // Write to the status register.
  logic wr_dreg; // Write to the data register.
  logic wr_ctrl; // Write to the enable register.
  logic wr_mask; // Write to the mask register.

  // Address and data are each accepted once per transaction, in either order.
  assign S_AXI_AWREADY = (wr_state == USF_WR_IDLE) || (wr_state == USF_WR_HAVE_DATA);
  assign S_AXI_WREADY = (wr_state == USF_WR_IDLE) || (wr_state == USF_WR_HAVE_ADDR);
  assign S_AXI_BVALID = (wr_state == USF_WR_RESP);
  assign S_AXI_BRESP = bresp;
  assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID && S_AXI_WREADY;

  // The write runs in the cycle the second half arrives, taking live values
  // for whichever half arrives now.
  assign wr_do = (wr_state == USF_WR_IDLE && aw_hs && w_hs) ||
                 (wr_state == USF_WR_HAVE_ADDR && w_hs) ||
                 (wr_state == USF_WR_HAVE_DATA && aw_hs);
  assign wr_addr = aw_hs ? S_AXI_AWADDR : aw_addr;
  assign wr_data = w_hs ? S_AXI_WDATA : w_data;
  assign wr_strb = w_hs ? S_AXI_WSTRB : w_strb;
  assign wr_lane0 = wr_strb[0];
  assign wr_hit = (wr_addr == `USF_STAT_OFS) || (wr_addr == `USF_DATA_OFS) ||
                  (wr_addr == `USF_CTRL_OFS) || (wr_addr == `USF_EVT_OFS) ||
                  (wr_addr == `USF_MASK_OFS);
  assign wr_stat = wr_do && wr_lane0 && (wr_addr == `USF_STAT_OFS);
  assign wr_dreg = wr_do && wr_lane0 && (wr_addr == `USF_DATA_OFS);
  assign wr_ctrl = wr_do && wr_lane0 && (wr_addr == `USF_CTRL_OFS);
  assign wr_mask = wr_do && wr_lane0 && (wr_addr == `USF_MASK_OFS);

  // Write transaction sequencer.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_state <= USF_WR_IDLE;
    end else begin
      unique case (wr_state)
        USF_WR_IDLE: begin
          if (aw_hs && w_hs) begin
            wr_state <= USF_WR_RESP;
          end else if (aw_hs) begin
            wr_state <= USF_WR_HAVE_ADDR;
          end else if (w_hs) begin
            wr_state <= USF_WR_HAVE_DATA;
          end
        end
        USF_WR_HAVE_ADDR: begin
          if (w_hs) begin
            wr_state <= USF_WR_RESP;
          end
        end
        USF_WR_HAVE_DATA: begin
          if (aw_hs) begin
            wr_state <= USF_WR_RESP;
          end
        end
        USF_WR_RESP: begin
          if (S_AXI_BREADY) begin
            wr_state <= USF_WR_IDLE;
          end
        end
      endcase
    end
  end

  // Hold whichever half arrived first, and the response code.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bresp <= `USF_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_do) begin
        // Unmapped addresses answer with a slave error and change nothing.
        bresp <= wr_hit ? `USF_RESP_OKAY : `USF_RESP_SLVERR;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel.

  logic rd_do; // Read address taken this cycle.
  logic rd_stat; // Status register read now.
  logic rd_dreg; // Data register read now.
  logic rd_evt; // Event register read now.
  logic [7:0] stat_val; // Status register image.
  logic [7:0] flag_en; // Enable register image.
  logic [31:0] next_rdata; // Value for the pending read.
  logic rd_hit; // Read address maps to a register.

  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RDATA = rdata;
  assign S_AXI_RRESP = rresp;
  assign rd_do = S_AXI_ARVALID && !rvalid;
  assign rd_stat = rd_do && (S_AXI_ARADDR == `USF_STAT_OFS);
  assign rd_dreg = rd_do && (S_AXI_ARADDR == `USF_DATA_OFS);
  assign rd_evt = rd_do && (S_AXI_ARADDR == `USF_EVT_OFS);

  // Register images; bits not listed read as zero.
  always_comb begin
    stat_val = 8'h00;
    stat_val[`USF_TXE_BIT] = tx_holding_empty_flag;
    stat_val[`USF_TC_BIT] = tx_complete_flag;
    stat_val[`USF_RX_DATA_READY_FLAG_BIT] = rx_data_ready_flag;
    stat_val[`USF_IDLE_BIT] = idle_line_flag;
    flag_en = 8'h00;
    flag_en[`USF_TXE_BIT] = tx_holding_empty_irq_en;
    flag_en[`USF_TC_BIT] = tx_complete_irq_en;
    flag_en[`USF_RX_DATA_READY_FLAG_BIT] = rx_data_ready_irq_en;
    flag_en[`USF_IDLE_BIT] = idle_line_irq_en;
  end

  // Read multiplexer.
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (S_AXI_ARADDR)
      `USF_STAT_OFS: next_rdata[7:0] = stat_val;
      `USF_DATA_OFS: next_rdata[DATA_W-1:0] = rx_data;
      `USF_CTRL_OFS: next_rdata[7:0] = flag_en;
      `USF_EVT_OFS: next_rdata[7:0] = evt;
      `USF_MASK_OFS: next_rdata[7:0] = mask;
      default: rd_hit = 1'b0;
    endcase
  end

  // One read at a time; the answer stands until the master takes it.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `USF_RESP_OKAY;
    end else if (rd_do) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= rd_hit ? `USF_RESP_OKAY : `USF_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit flags.

  // Holding-empty flag: hardware sets it when the shifter loads, software
  // clears it by writing the data register. A write in the same cycle as the
  // load refills the now empty holding register, so the flag ends clear.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_holding_empty_flag <= `USF_TXE_RST;
    end else if (wr_dreg) begin
      tx_holding_empty_flag <= 1'b0;
    end else if (TX_SHIFT_LOAD) begin
      tx_holding_empty_flag <= 1'b1;
    end
  end

  // Holding register contents.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_holding_register <= '0;
    end else if (wr_dreg) begin
      tx_holding_register <= wr_data[DATA_W-1:0];
    end
  end

  // Complete flag: set at a frame end with the holding register empty; the
  // set wins over any clear in the same cycle.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_complete_flag <= `USF_TC_RST;
    end else if (TX_FRAME_DONE && tx_holding_empty_flag) begin
      tx_complete_flag <= 1'b1;
    end else if (wr_dreg && tc_armed) begin
      tx_complete_flag <= 1'b0;
    end else if (wr_stat && !wr_data[`USF_TC_BIT]) begin
      tx_complete_flag <= 1'b0;
    end
  end

  // Remember that software has seen the complete flag; the next data write
  // then clears it. A data write alone does not.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tc_armed <= 1'b0;
    end else if (wr_dreg || !tx_complete_flag) begin
      tc_armed <= 1'b0;
    end else if (rd_stat) begin
      tc_armed <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive flags.

  // Received word and data-ready flag; a new word wins over a clear.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_data_ready_flag <= `USF_RX_DATA_READY_FLAG_RST;
      rx_data <= '0;
    end else if (RX_WORD_VALID) begin
      rx_data_ready_flag <= 1'b1;
      rx_data <= RX_WORD;
    end else if (wr_dreg || (wr_stat && !wr_data[`USF_RX_DATA_READY_FLAG_BIT])) begin
      rx_data_ready_flag <= 1'b0;
    end
  end

  // Idle flag: writes never touch it; only the read pair clears it.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      idle_line_flag <= `USF_IDLE_RST;
    end else if (RX_IDLE_DETECT) begin
      idle_line_flag <= 1'b1;
    end else if (rd_dreg && idle_armed) begin
      idle_line_flag <= 1'b0;
    end
  end

  // A status read that sees the idle flag arms the clear by the data read.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      idle_armed <= 1'b0;
    end else if (rd_dreg || !idle_line_flag) begin
      idle_armed <= 1'b0;
    end else if (rd_stat) begin
      idle_armed <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enables, events and mask.

  // Interrupt enables, in the same bit layout as the flags.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_holding_empty_irq_en <= 1'b0;
      tx_complete_irq_en <= 1'b0;
      rx_data_ready_irq_en <= 1'b0;
      idle_line_irq_en <= 1'b0;
    end else if (wr_ctrl) begin
      tx_holding_empty_irq_en <= wr_data[`USF_TXE_BIT];
      tx_complete_irq_en <= wr_data[`USF_TC_BIT];
      rx_data_ready_irq_en <= wr_data[`USF_RX_DATA_READY_FLAG_BIT];
      idle_line_irq_en <= wr_data[`USF_IDLE_BIT];
    end
  end

  // Sticky events catch short causes that software cleared before looking.
  // A read clears them, but an event in the same cycle survives.
  logic [7:0] evt_set; // Events seen this cycle.

  always_comb begin
    evt_set = 8'h00;
    evt_set[`USF_TXE_BIT] = TX_SHIFT_LOAD;
    evt_set[`USF_TC_BIT] = TX_FRAME_DONE && tx_holding_empty_flag;
    evt_set[`USF_RX_DATA_READY_FLAG_BIT] = RX_WORD_VALID;
    evt_set[`USF_IDLE_BIT] = RX_IDLE_DETECT;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      evt <= 8'h00;
    end else if (rd_evt) begin
      evt <= evt_set;
    end else begin
      evt <= evt | evt_set;
    end
  end

  // Event mask; only the four flag positions are kept.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mask <= 8'h00;
    end else if (wr_mask) begin
      mask <= wr_data[7:0] & 8'hf0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The request is registered, so it follows its cause by one cycle.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (tx_holding_empty_flag && tx_holding_empty_irq_en) ||
             (tx_complete_flag && tx_complete_irq_en) ||
             (rx_data_ready_flag && rx_data_ready_irq_en) ||
             (idle_line_flag && idle_line_irq_en) ||
             (|(evt & mask));
    end
  end

  assign TX_HOLD_DATA = tx_holding_register;
  assign TX_HOLD_FULL = !tx_holding_empty_flag;

endmodule
`default_nettype wire

// *** pkg/usf_defines.svh ***
// Register offsets, field positions, reset values and bus codes of the status flag block.
`ifndef USF_DEFINES_SVH
`define USF_DEFINES_SVH

// Byte addresses of the registers on the register bus.
`define USF_STAT_OFS 8'h00
`define USF_DATA_OFS 8'h04
`define USF_CTRL_OFS 8'h08
`define USF_EVT_OFS 8'h0c
`define USF_MASK_OFS 8'h10

// Bit positions shared by the status, enable, event and mask registers.
`define USF_TXE_BIT 7
`define USF_TC_BIT 6
`define USF_RX_DATA_READY_FLAG_BIT 5
`define USF_IDLE_BIT 4

// Reset values of the flags.
`define USF_TXE_RST 1'b1
`define USF_TC_RST 1'b1
`define USF_RX_DATA_READY_FLAG_RST 1'b0
`define USF_IDLE_RST 1'b0

// Bus response codes.
`define USF_RESP_OKAY 2'b00
`define USF_RESP_SLVERR 2'b10

`endif

// *** pkg/usf_pkg.sv ***
// Types shared by the status flag block.
package usf_pkg;

  // Bus response code.
  typedef logic [1:0] usf_resp_t;

  // Progress of one write transaction on the register bus.
  typedef enum logic [1:0] {
    USF_WR_IDLE = 2'b00,
    USF_WR_HAVE_ADDR = 2'b01,
    USF_WR_HAVE_DATA = 2'b10,
    USF_WR_RESP = 2'b11
  } usf_wr_state_e;

endpackage

// *** tb/usf_status_flags_assertions.sv ***
// Port-level checker for the status flag block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "usf_defines.svh"

module usf_status_flags_assertions #(
  parameter int DATA_W = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire usf_pkg::usf_resp_t S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire usf_pkg::usf_resp_t S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [DATA_W-1:0] TX_HOLD_DATA,
  input wire logic TX_HOLD_FULL,
  input wire logic TX_SHIFT_LOAD,
  input wire logic RX_WORD_VALID,
  input wire logic IRQ
);
  import usf_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // A write that completes in one edge, address and data together.
  logic wr_both;
  assign wr_both = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;

  ////////////////////////////////////////////////////////////////////////////////
  // A data write fills the holding register with the written byte.
  a_write_fills_hold: assert property (wr_both && S_AXI_AWADDR == `USF_DATA_OFS
    && S_AXI_WSTRB[0] |=> TX_HOLD_FULL && TX_HOLD_DATA == $past(S_AXI_WDATA[DATA_W-1:0]))
    else $error("holding register not filled by data write");
  // A load by the shifter with no write pending leaves the holding register empty.
  a_load_empties: assert property (TX_SHIFT_LOAD && !S_AXI_AWVALID
    && !S_AXI_WVALID |=> !TX_HOLD_FULL)
    else $error("holding register still full after shifter load");
  // With no load and no write, a full holding register keeps its word.
  a_hold_stands: assert property (TX_HOLD_FULL && !TX_SHIFT_LOAD && !S_AXI_AWVALID
    && !S_AXI_WVALID |=> TX_HOLD_FULL && $stable(TX_HOLD_DATA))
    else $error("holding register changed without cause");
  a_write_answers: assert property (wr_both |=> S_AXI_BVALID)
    else $error("write response missing");
  a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before ready");
  a_read_answers: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data missing");
  a_rdata_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
    else $error("read data dropped before ready");
  a_unmapped_err: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h10
    |=> S_AXI_RRESP == `USF_RESP_SLVERR && S_AXI_RDATA == 32'h00000000)
    else $error("unmapped read not refused");

  // Main scenarios that the bench must reach.
  c_irq_rise: cover property ($rose(IRQ));
  c_load: cover property (TX_SHIFT_LOAD ##1 !TX_HOLD_FULL);
  c_rx_irq: cover property (RX_WORD_VALID ##2 IRQ);
endmodule

bind usf_status_flags usf_status_flags_assertions #(.DATA_W(DATA_W)) chk (.*);
`default_nettype wire

// *** tb/usf_remote_link.sv ***
// Behavioural model of the remote serial transceiver beside the flag block.
`timescale 1ns/1ps
`default_nettype none

module usf_remote_link #(
  parameter int FRAME = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_en,
  input wire logic hold_full,
  input wire logic rx_go,
  input wire logic idle_go,
  input wire logic [7:0] rx_val,
  output logic shift_load = 1'b0,
  output logic frame_done = 1'b0,
  output logic word_valid = 1'b0,
  output logic idle_det = 1'b0,
  output logic [7:0] word = 8'h00
);
  int cnt; // Cycles left in the frame on the wire.
  logic busy = 1'b0; // A frame is being shifted out.

  // Transmit: take the held word while enabled, then end the frame later.
  // Holding tx_en low keeps the shifter from taking a word; a frame already under way still runs to its end.
  always @(posedge clk) begin
    shift_load <= 1'b0;
    frame_done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        busy <= 1'b0;
        frame_done <= 1'b1;
      end
    end else if (tx_en && hold_full && !shift_load) begin
      shift_load <= 1'b1;
      busy <= 1'b1;
      cnt <= FRAME;
    end
  end

  // Receive: a word is valid for one cycle, the bus shows a moving pattern otherwise.
  always @(posedge clk) begin
    word_valid <= rx_go && !rst;
    idle_det <= idle_go && !rst;
    word <= rx_go ? rx_val : ~word;
  end
endmodule
`default_nettype wire

// *** tb/usf_status_flags_bench.sv ***
// Self-checking bench for the status flag block.
`timescale 1ns/1ps
`default_nettype none
`include "usf_defines.svh"

module usf_status_flags_bench;
  import usf_pkg::*;
  logic CLK_SYS = 1'b0, RST = 1'b1;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_ARVALID = 0;
  logic S_AXI_BREADY = 1, S_AXI_RREADY = 1;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  usf_resp_t S_AXI_BRESP, S_AXI_RRESP;
  logic [7:0] TX_HOLD_DATA, RX_WORD;
  logic TX_HOLD_FULL, TX_SHIFT_LOAD, TX_FRAME_DONE, RX_WORD_VALID, RX_IDLE_DETECT, IRQ;
  logic tx_en = 0, rx_go = 0, idle_go = 0;
  logic [7:0] rx_val = 8'h00;
  logic [31:0] d, w;
  logic [1:0] r;
  int miscompares = 0, samples_checked = 0;

  always #5 CLK_SYS = ~CLK_SYS;

  usf_status_flags dut (.*);
  usf_remote_link far (.clk(CLK_SYS), .rst(RST), .tx_en(tx_en), .hold_full(TX_HOLD_FULL),
    .rx_go(rx_go), .idle_go(idle_go), .rx_val(rx_val), .shift_load(TX_SHIFT_LOAD),
    .frame_done(TX_FRAME_DONE), .word_valid(RX_WORD_VALID), .idle_det(RX_IDLE_DETECT),
    .word(RX_WORD));

  ////////////////////////////////////////////////////////////////////////////////
  // Expected status word from the four flags.
  function automatic logic [31:0] stat(input logic e, c, rx, i);
    return {24'h0, e, c, rx, i, 4'h0};
  endfunction

  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      miscompares++;
    end
  endtask

  // Write: address and data offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, wd;
    aw = 0;
    wd = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    while (!(aw && wd)) begin
      @(posedge CLK_SYS);
      if (!aw && S_AXI_AWREADY) begin
        aw = 1;
        S_AXI_AWVALID <= 0;
      end
      if (!wd && S_AXI_WREADY) begin
        wd = 1;
        S_AXI_WVALID <= 0;
      end
    end
    do @(posedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
  endtask

  // Read: the answer is taken at the edge where valid is seen.
  task automatic rd(input logic [7:0] a);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    do @(posedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 0;
    do @(posedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  task automatic pulse_far(input logic idle, input logic [7:0] v);
    rx_val <= v;
    if (idle) idle_go <= 1;
    else rx_go <= 1;
    @(posedge CLK_SYS);
    idle_go <= 0;
    rx_go <= 0;
    settle(4);
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // A hang is cut short well past the few hundred cycles the tests need.
  initial begin
    settle(20000);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    w = $urandom(19712);
    settle(4);
    RST <= 0;
    rd(`USF_STAT_OFS);
    cmp_word("status after reset", stat(1, 1, 0, 0), d);
    rd(8'h14);
    cmp_word("unmapped read resp", {30'h0, `USF_RESP_SLVERR}, {30'h0, r});
    cmp_word("unmapped read data", 32'h0, d);
    wr(8'h20, 32'hff);
    cmp_word("unmapped write resp", {30'h0, `USF_RESP_SLVERR}, {30'h0, r});
    wr(`USF_CTRL_OFS, 32'h80);
    settle(3);
    cmp_bit("irq holding empty", 1, IRQ);
    w = $urandom;
    wr(`USF_DATA_OFS, w);
    rd(`USF_STAT_OFS);
    cmp_word("status after data write", stat(0, 0, 0, 0), d);
    cmp_word("holding data", {24'h0, w[7:0]}, {24'h0, TX_HOLD_DATA});
    cmp_bit("holding full", 1, TX_HOLD_FULL);
    cmp_bit("irq after data write", 0, IRQ);
    tx_en <= 1;
    settle(12);
    rd(`USF_STAT_OFS);
    cmp_word("status after frame", stat(1, 1, 0, 0), d);
    wr(`USF_STAT_OFS, 32'h0);
    rd(`USF_STAT_OFS);
    cmp_word("status zero write", stat(1, 0, 0, 0), d);
    wr(`USF_CTRL_OFS, 32'h40);
    settle(3);
    cmp_bit("irq complete clear", 0, IRQ);
    wr(`USF_DATA_OFS, $urandom);
    // The second word lands while the shifter loads the first, so the frame ends with the
    // holding register full and must not raise the complete flag.
    wr(`USF_DATA_OFS, $urandom);
    settle(6);
    rd(`USF_STAT_OFS);
    cmp_bit("complete held while holding full", 0, d[`USF_TC_BIT]);
    settle(12);
    cmp_bit("irq complete set", 1, IRQ);
    // A data write with no status read before it leaves the complete flag alone.
    w = $urandom;
    wr(`USF_DATA_OFS, w);
    cmp_word("data write resp", {30'h0, `USF_RESP_OKAY}, {30'h0, r});
    rd(`USF_STAT_OFS);
    cmp_word("status read resp", {30'h0, `USF_RESP_OKAY}, {30'h0, r});
    cmp_bit("complete kept by lone data write", 1, d[`USF_TC_BIT]);
    wr(`USF_CTRL_OFS, 32'h20);
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      pulse_far(0, w[7:0]);
      cmp_bit("irq data ready", 1, IRQ);
      rd(`USF_STAT_OFS);
      cmp_word("status data ready", stat(1, 1, 1, 0), d);
      rd(`USF_DATA_OFS);
      cmp_word("received word", {24'h0, w[7:0]}, d);
      if (i[0]) wr(`USF_DATA_OFS, w);
      else wr(`USF_STAT_OFS, 32'h40);
      settle(12);
      cmp_bit("irq data ready clear", 0, IRQ);
      rd(`USF_STAT_OFS);
      cmp_word("status ready cleared", stat(1, 1, 0, 0), d);
    end
    wr(`USF_CTRL_OFS, 32'h10);
    pulse_far(1, 8'h00);
    cmp_bit("irq idle", 1, IRQ);
    rd(`USF_DATA_OFS);
    rd(`USF_STAT_OFS);
    cmp_word("idle kept by lone data read", stat(1, 1, 0, 1), d);
    rd(`USF_DATA_OFS);
    rd(`USF_STAT_OFS);
    cmp_word("idle cleared", stat(1, 1, 0, 0), d);
    settle(3);
    cmp_bit("irq idle clear", 0, IRQ);
    wr(`USF_CTRL_OFS, 32'h0);
    rd(`USF_EVT_OFS);
    wr(`USF_MASK_OFS, 32'h20);
    pulse_far(0, 8'h3c);
    cmp_bit("irq from event", 1, IRQ);
    rd(`USF_EVT_OFS);
    cmp_word("event register", 32'h20, d);
    settle(3);
    cmp_bit("irq after event read", 0, IRQ);
    rd(`USF_MASK_OFS);
    cmp_word("mask register", 32'h20, d);
    tally_and_finish();
  end
endmodule
`default_nettype wire
